/* rtl/drtc_defines.svh */
// Constants of the dual real-time counter block: field positions, reset values, timing counts.
// Assumes the including file sees the drtc_pkg types where it needs them.
//
// Overview of operation
// RULE1: Seconds counter divides crystal to one hertz.
// RULE2: Scalable counter prescales by two power 0..15.
// RULE3: Scalable source is crystal or RC oscillator.
// RULE4: Seconds counter has one absolute seconds alarm.
// RULE5: Scalable alarm resolves single source clock cycles.
// RULE6: Absolute alarm plus periodic every sixty units.
// RULE7: Enabled timed pulse drives pin at target.
// RULE8: Pulse scheduled against scalable running count.
// RULE9: Timed pulse works in all power modes.
// RULE10: Input transition latches scalable count snapshot.
// RULE11: Capture can wake device and interrupt.
// RULE12: Snapshot names exact source clock cycle.
// RULE13: Interrupt when counter equals alarm value.
// RULE14: Digital trim corrects count at intervals.
// RULE15: Both counters share the crystal oscillator.
// RULE16: Event flags stay set until software clears.
`ifndef DRTC_DEFINES_SVH
`define DRTC_DEFINES_SVH

// ------------------------------------------------------------
// Time base
// ------------------------------------------------------------
`define DRTC_XTAL_HZ        32768
`define DRTC_SEC_EXP        4'hf
`define DRTC_PERIOD_UNITS   60
`define DRTC_PERIOD_LAST    6'(`DRTC_PERIOD_UNITS - 1)

// ------------------------------------------------------------
// Source select and capture edge encodings
// ------------------------------------------------------------
`define DRTC_SRC_RC         1'b1
`define DRTC_EDGE_RISE      0
`define DRTC_EDGE_FALL      1

// ------------------------------------------------------------
// Sticky flag positions
// ------------------------------------------------------------
`define DRTC_FLG_SEC_ALARM  0
`define DRTC_FLG_SCL_ALARM  1
`define DRTC_FLG_PERIOD     2
`define DRTC_FLG_CAPTURE    3
`define DRTC_FLG_W          4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DRTC_COUNT_RST      32'h0000_0000
`define DRTC_FRAC_RST       15'h0000
`define DRTC_FLAGS_RST      4'h0
`define DRTC_PWR_ACTIVE     2'h0

`endif

/* rtl/drtc_pkg.sv */
// Types shared by the dual real-time counter files.
// Assumes nothing of its surroundings.
package drtc_pkg;
   typedef logic [31:0] drtc_count_t;   // Whole counted units
   typedef logic [14:0] drtc_frac_t;    // Source cycles inside a unit
   typedef enum logic [1:0] {
      drtc_st_idle  = 2'b00,
      drtc_st_armed = 2'b01,
      drtc_st_pulse = 2'b10
   } drtc_strobe_e;
endpackage : drtc_pkg

/* rtl/drtc_prescaler.sv */
// Power-of-two prescaler: counts source ticks, emits a unit tick every 2^exp ticks.
// Assumes src_tick is a one-cycle pulse synchronous to core_clk.
`include "drtc_defines.svh"

module drtc_prescaler import drtc_pkg::*; (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Source and setting
   input  wire logic       src_tick,
   input  wire logic [3:0] unit_exp,
   // Phase and unit tick
   output drtc_frac_t      frac_q,
   output logic            unit_tick
);

   // ------------------------------------------------------------
   // Phase mask, one bit per prescaler stage
   // ------------------------------------------------------------
   drtc_frac_t mask;   // Last phase value of a unit

   genvar i;
   for (i = 0; i < 15; i++) begin : g_mask
      assign mask[i] = (unit_exp > 4'(i));
   end

   // Unit ends on the tick that finds the phase at or above the mask
   assign unit_tick = src_tick && (frac_q >= mask);   // RULE2

   // Phase counter, one step per source cycle
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         frac_q <= `DRTC_FRAC_RST;
      end else if (src_tick) begin
         frac_q <= unit_tick ? `DRTC_FRAC_RST : frac_q + 15'h1;   // RULE5
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_prescale_wrap: assert property (@(posedge core_clk) disable iff (reset)   // RULE2
      unit_tick |=> frac_q == 15'h0)
      else $error("phase did not restart after unit tick");

   a_phase_step: assert property (@(posedge core_clk) disable iff (reset)   // RULE5
      src_tick && !unit_tick |=> frac_q == $past(frac_q) + 15'h1)
      else $error("phase did not advance on a source cycle");

endmodule // drtc_prescaler

/* rtl/drtc_dual_rtc.sv */
// Top of the dual real-time counter: seconds counter, scalable counter, alarms,
// timed sensor pulse and input capture. All settings are plain ports.
// Assumes oscillator and capture inputs are synchronous to core_clk.
`include "drtc_defines.svh"

module drtc_dual_rtc import drtc_pkg::*; (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Low-frequency oscillators
   input  wire logic        low_freq_crystal_osc,
   input  wire logic        low_freq_rc_osc,
   input  wire logic        low_freq_source_select,
   // Scalable counter setup
   input  wire logic [3:0]  scalable_time_unit,
   // Alarms
   input  wire logic        sec_alarm_en,
   input  wire logic [31:0] sec_alarm_time,
   input  wire logic        scl_alarm_en,
   input  wire logic [31:0] scl_alarm_units,
   input  wire logic [14:0] scl_alarm_frac,
   input  wire logic        scl_period_en,
   // Digital trim
   input  wire logic        trim_en,
   input  wire logic [15:0] trim_interval,
   input  wire logic [7:0]  sec_trim,
   input  wire logic [7:0]  scl_trim,
   // Timed sensor pulse
   input  wire logic        strobe_en,
   input  wire logic [31:0] strobe_target,
   input  wire logic [1:0]  power_mode,
   // Input capture
   input  wire logic        cap_in,
   input  wire logic        cap_en,
   input  wire logic [1:0]  cap_edge_sel,
   input  wire logic        cap_wake_en,
   // Flag handling
   input  wire logic [3:0]  irq_en,
   input  wire logic [3:0]  flag_clr,
   // Sensor pin
   output logic             timed_sensor_pulse_out,
   output logic             timed_sensor_pulse_oe,
   // Status
   output drtc_count_t      sec_count,
   output drtc_count_t      scl_count,
   output drtc_frac_t       scl_frac,
   output drtc_count_t      cap_units,
   output drtc_frac_t       cap_frac,
   output logic [3:0]       flags,
   output logic             irq,
   output logic             wake_req
);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // Source cycle detection
   // ------------------------------------------------------------
   logic xtal_q;          // Crystal level, one cycle late
   logic rc_q;            // RC level, one cycle late
   logic xtal_tick;       // Crystal rising edge
   logic rc_tick;         // RC rising edge
   logic [1:0] src_tick;  // Per-counter source tick

   // Edge history of both oscillators
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         xtal_q <= 1'b0;
         rc_q   <= 1'b0;
      end else begin
         xtal_q <= low_freq_crystal_osc;
         rc_q   <= low_freq_rc_osc;
      end
   end

   assign xtal_tick = low_freq_crystal_osc & ~xtal_q;
   assign rc_tick   = low_freq_rc_osc & ~rc_q;

   // Crystal feeds the seconds counter, and the scalable counter unless RC is selected
   assign src_tick[0] = xtal_tick;   // RULE15
   // Scalable counter picks its source
   assign src_tick[1] = (low_freq_source_select == `DRTC_SRC_RC) ? rc_tick : xtal_tick;   // RULE3 RULE15

   // ------------------------------------------------------------
   // Prescalers and counters, one per counter
   // ------------------------------------------------------------
   logic [3:0]  unit_exp  [2];   // Prescale exponent per counter
   drtc_frac_t  frac_q    [2];   // Phase per counter
   logic [1:0]  unit_tick;       // Unit tick per counter
   drtc_count_t cnt_q     [2];   // Counted units
   logic [15:0] trim_cnt_q[2];   // Units since last trim
   logic [7:0]  trim_val  [2];   // Signed trim per counter
   logic [1:0]  trim_hit;        // Trim applies on this tick

   // Seconds counter is fixed at divide by 32768
   assign unit_exp[0] = `DRTC_SEC_EXP;   // RULE1
   assign unit_exp[1] = scalable_time_unit;   // RULE2
   assign trim_val[0] = sec_trim;
   assign trim_val[1] = scl_trim;

   genvar c;
   for (c = 0; c < 2; c++) begin : g_cnt
      drtc_prescaler u_pre (
         .core_clk  (core_clk),
         .reset     (reset),
         .src_tick  (src_tick[c]),
         .unit_exp  (unit_exp[c]),
         .frac_q    (frac_q[c]),
         .unit_tick (unit_tick[c])
      );

      // Trim falls due when the interval of units has passed
      assign trim_hit[c] = trim_en && unit_tick[c] && (trim_cnt_q[c] == trim_interval);

      // Interval counter for the trim
      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            trim_cnt_q[c] <= 16'h0;
         end else if (!trim_en) begin
            trim_cnt_q[c] <= 16'h0;
         end else if (unit_tick[c]) begin
            trim_cnt_q[c] <= trim_hit[c] ? 16'h0 : trim_cnt_q[c] + 16'h1;
         end
      end

      // Count advances one unit, plus the signed trim when due
      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            cnt_q[c] <= `DRTC_COUNT_RST;
         end else if (trim_hit[c]) begin
            cnt_q[c] <= cnt_q[c] + 32'h1 + {{24{trim_val[c][7]}}, trim_val[c]};   // RULE14
         end else if (unit_tick[c]) begin
            cnt_q[c] <= cnt_q[c] + 32'h1;   // RULE1
         end
      end
   end

   assign sec_count = cnt_q[0];
   assign scl_count = cnt_q[1];
   assign scl_frac  = frac_q[1];

   // ------------------------------------------------------------
   // Alarms
   // ------------------------------------------------------------
   logic       sec_alarm_hit;   // Seconds alarm match
   logic       scl_alarm_hit;   // Scalable absolute alarm match
   logic       period_hit;      // Sixtieth unit passed
   logic [5:0] per_cnt_q;       // Units inside the period

   // Absolute seconds alarm, checked as each second ends
   assign sec_alarm_hit = sec_alarm_en && unit_tick[0] && (cnt_q[0] == sec_alarm_time);   // RULE4 RULE13

   // Absolute alarm to one source cycle
   assign scl_alarm_hit = scl_alarm_en && src_tick[1]
                          && (cnt_q[1] == scl_alarm_units) && (frac_q[1] == scl_alarm_frac);   // RULE5 RULE6

   assign period_hit = scl_period_en && unit_tick[1] && (per_cnt_q == `DRTC_PERIOD_LAST);   // RULE6

   // Period counter restarts when disabled
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         per_cnt_q <= 6'h0;
      end else if (!scl_period_en) begin
         per_cnt_q <= 6'h0;
      end else if (unit_tick[1]) begin
         per_cnt_q <= period_hit ? 6'h0 : per_cnt_q + 6'h1;   // RULE6
      end
   end

   // ------------------------------------------------------------
   // Timed sensor pulse
   // ------------------------------------------------------------
   drtc_strobe_e st_q;       // Pulse state
   logic         st_fire;    // Target reached while armed
   logic         pulse_q;    // Pin level

   // Target compared against running scalable count at unit start, only while enabled
   assign st_fire = (st_q == drtc_st_armed) && strobe_en && src_tick[1]
                    && (cnt_q[1] == strobe_target) && (frac_q[1] == 15'h0);   // RULE8

   // Not gated by power_mode: runs in active, partial sleep, hibernate
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= drtc_st_idle;
      end else begin
         case (st_q)
            // Wait for enable
            drtc_st_idle: begin
               if (strobe_en) begin
                  st_q <= drtc_st_armed;   // RULE9
               end
            end
            // Wait for the target time
            drtc_st_armed: begin
               if (!strobe_en) begin
                  st_q <= drtc_st_idle;
               end else if (st_fire) begin
                  st_q <= drtc_st_pulse;   // RULE7
               end
            end
            // Pulse lasts one source cycle
            drtc_st_pulse: begin
               if (src_tick[1]) begin
                  st_q <= strobe_en ? drtc_st_armed : drtc_st_idle;
               end
            end
            default: begin
               st_q <= drtc_st_idle;
            end
         endcase
      end
   end

   // Pin level and drive enable from flops
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pulse_q               <= 1'b0;
         timed_sensor_pulse_oe <= 1'b0;
      end else begin
         pulse_q               <= (st_q == drtc_st_pulse) ? !src_tick[1] : st_fire;   // RULE7
         timed_sensor_pulse_oe <= strobe_en;
      end
   end

   assign timed_sensor_pulse_out = pulse_q;

   // ------------------------------------------------------------
   // Input capture
   // ------------------------------------------------------------
   logic cap_q;     // Capture pin, one cycle late
   logic cap_hit;   // Selected transition seen

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cap_q <= 1'b0;
      end else begin
         cap_q <= cap_in;
      end
   end

   // Rising, falling or both, as selected
   assign cap_hit = cap_en && ((cap_edge_sel[`DRTC_EDGE_RISE] && cap_in && !cap_q)
                              || (cap_edge_sel[`DRTC_EDGE_FALL] && !cap_in && cap_q));   // RULE10

   // Snapshot of units and source-cycle phase
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cap_units <= `DRTC_COUNT_RST;
         cap_frac  <= `DRTC_FRAC_RST;
      end else if (cap_hit) begin
         cap_units <= cnt_q[1];   // RULE10
         cap_frac  <= frac_q[1];   // RULE12
      end
   end

   // ------------------------------------------------------------
   // Sticky flags, interrupt and wake
   // ------------------------------------------------------------
   logic [3:0] flag_set;   // Events this cycle
   logic [3:0] flags_q;    // Sticky flags

   assign flag_set = {cap_hit, period_hit, scl_alarm_hit, sec_alarm_hit};

   // Set wins over a clear in the same cycle
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         flags_q <= `DRTC_FLAGS_RST;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;   // RULE16
      end
   end

   assign flags    = flags_q;
   assign irq      = |(flags_q & irq_en);   // RULE13 RULE11
   // Capture wakes the device only outside active mode
   assign wake_req = cap_wake_en && flags_q[`DRTC_FLG_CAPTURE] && (power_mode != `DRTC_PWR_ACTIVE);   // RULE11

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_cap_event;
      cap_hit;
   endsequence

   sequence s_snap_taken;
      (cap_units == $past(cnt_q[1])) && (cap_frac == $past(frac_q[1])) && flags_q[`DRTC_FLG_CAPTURE];
   endsequence

   a_sec_advance: assert property (   // RULE1
      unit_tick[0] && !trim_hit[0] |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
      else $error("seconds count did not step by one");

   a_trim_apply: assert property (   // RULE14
      trim_hit[1] |=> cnt_q[1] == $past(cnt_q[1]) + 32'h1 + {{24{$past(scl_trim[7])}}, $past(scl_trim)})
      else $error("trim not added to scalable count");

   a_source_select: assert property (   // RULE3
      (low_freq_source_select == `DRTC_SRC_RC) && !rc_tick |-> !src_tick[1])
      else $error("scalable counter ticked off the unselected source");

   a_sec_alarm_flag: assert property (   // RULE4
      sec_alarm_hit |=> flags_q[`DRTC_FLG_SEC_ALARM] && (irq || !irq_en[`DRTC_FLG_SEC_ALARM]))
      else $error("seconds alarm flag not raised");

   a_period_sixty: assert property (   // RULE6
      period_hit |-> per_cnt_q == `DRTC_PERIOD_LAST ##1 per_cnt_q == 6'h0)
      else $error("periodic alarm not at sixtieth unit");

   a_strobe_pulse: assert property (   // RULE7
      st_fire |=> pulse_q && st_q == drtc_st_pulse)
      else $error("timed pulse did not start at target");

   a_strobe_target: assert property (   // RULE8
      $rose(pulse_q) |-> $past(cnt_q[1]) == $past(strobe_target))
      else $error("timed pulse away from target count");

   a_capture_snap: assert property (   // RULE10
      s_cap_event |=> s_snap_taken)
      else $error("capture snapshot not taken");

   a_capture_wake: assert property (   // RULE11
      cap_hit && cap_wake_en && power_mode != `DRTC_PWR_ACTIVE |=> wake_req)
      else $error("capture did not request wake");

   a_flag_sticky: assert property (   // RULE16
      flags_q[`DRTC_FLG_SCL_ALARM] && !flag_clr[`DRTC_FLG_SCL_ALARM] |=> flags_q[`DRTC_FLG_SCL_ALARM])
      else $error("sticky flag dropped without clear");

endmodule // drtc_dual_rtc

/* sim/drtc_sensor_model.sv */
// External sensor model: answers each timed pulse with one transition on its event line.
// Assumes the pulse pin level is sampled on core_clk and the event line is read synchronously.
module drtc_sensor_model #(
   parameter int DELAY = 1   // Core cycles from pulse seen to event edge
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Pin levels
   input  wire logic strobe_pin,
   output logic      event_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   logic prev_q;   // Pulse pin one cycle ago
   int   wait_q;   // Cycles left to the event edge, 0 when idle

   // ------------------------------------------------------------
   // Measurement timing
   // ------------------------------------------------------------
   // Start on each rising pulse, then flip the event line after DELAY
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prev_q    <= 1'b0;
         wait_q    <= 0;
         event_pin <= 1'b0;
      end else begin
         prev_q <= strobe_pin;
         if (strobe_pin && !prev_q) begin   // Pulse start
            wait_q <= DELAY;
         end else if (wait_q == 1) begin    // Measurement done: signal it
            event_pin <= ~event_pin;
            wait_q    <= 0;
         end else if (wait_q > 1) begin     // Still measuring
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule // drtc_sensor_model

/* sim/drtc_dual_rtc_tb_top.sv */
// Self-checking bench of the dual real-time counter with a sensor model on the pulse pin.
// Assumes the design and package under rtl/ are compiled first; oscillators are bench driven.
module drtc_dual_rtc_tb_top;
   import drtc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic core_clk = 1'b0;       // 40 MHz clock
   logic reset    = 1'b1;       // Async reset, active high
   logic xtal, rc, src_sel;     // Oscillator levels and selector
   logic [3:0]  unit_exp;       // Prescale exponent
   logic        sec_en, scl_en, per_en, stb_en, cap_en, wake_en, cap_pin;
   logic [31:0] sec_time, scl_units, stb_target;
   logic [14:0] scl_frac_t;     // Alarm phase
   logic [1:0]  pmode, edge_sel;
   logic [3:0]  irq_en, flag_clr;
   logic        trim_on;              // Trim enable
   logic [15:0] trim_int;             // Trim interval
   logic [7:0]  sec_tr, scl_tr;       // Signed trims
   logic        pulse_out, pulse_oe, irq, wake_req, pin_level;
   drtc_count_t sec_count, scl_count, cap_units;
   drtc_frac_t  scl_frac, cap_frac;
   logic [3:0]  flags;
   int          failures = 0;         // Mismatch count
   int          samples_checked = 0;  // Comparison count
   int          pulses = 0;           // Rising pulses on the pin
   int          cycles = 0;           // Timeout counter
   logic        pin_prev = 1'b0;      // Pin level one cycle ago

   // Pulled-down pin: low whenever the design does not drive it
   assign pin_level = pulse_oe ? pulse_out : 1'b0;

   // ------------------------------------------------------------
   // Design and sensor
   // ------------------------------------------------------------
   drtc_dual_rtc drtc_dual_rtc_i (
      .core_clk(core_clk), .reset(reset), .low_freq_crystal_osc(xtal), .low_freq_rc_osc(rc),
      .low_freq_source_select(src_sel), .scalable_time_unit(unit_exp), .sec_alarm_en(sec_en),
      .sec_alarm_time(sec_time), .scl_alarm_en(scl_en), .scl_alarm_units(scl_units),
      .scl_alarm_frac(scl_frac_t), .scl_period_en(per_en), .trim_en(trim_on), .trim_interval(trim_int),
      .sec_trim(sec_tr), .scl_trim(scl_tr), .strobe_en(stb_en), .strobe_target(stb_target),
      .power_mode(pmode), .cap_in(cap_pin), .cap_en(cap_en), .cap_edge_sel(edge_sel),
      .cap_wake_en(wake_en), .irq_en(irq_en), .flag_clr(flag_clr),
      .timed_sensor_pulse_out(pulse_out), .timed_sensor_pulse_oe(pulse_oe), .sec_count(sec_count),
      .scl_count(scl_count), .scl_frac(scl_frac), .cap_units(cap_units), .cap_frac(cap_frac),
      .flags(flags), .irq(irq), .wake_req(wake_req));

   drtc_sensor_model #(.DELAY(1)) drtc_sensor_model_i (
      .core_clk(core_clk), .reset(reset), .strobe_pin(pin_level), .event_pin(cap_pin));

   // ------------------------------------------------------------
   // Clock, pulse counter and timeout
   // ------------------------------------------------------------
   always #12.5 core_clk = ~core_clk;

   // Count rising pulses; cut a hang short
   always @(posedge core_clk) begin
      pin_prev <= pin_level;
      if (pin_level && !pin_prev) pulses++;
      cycles++;
      if (cycles == 90000) begin
         failures++;
         $display("ERROR at %0t: run timed out", $time);
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
      samples_checked++;
      if (seen !== expv) begin
         failures++;
         $display("ERROR at %0t: %s saw %0h expected %0h", $time, what, seen, expv);
      end
   endtask

   // Idle settings, 5 cycles of reset, pulse counter cleared
   task automatic do_reset();
      {xtal, rc, src_sel, sec_en, scl_en, per_en, stb_en, cap_en, wake_en} = '0;
      {unit_exp, pmode, edge_sel, irq_en, flag_clr, scl_frac_t} = '0;
      {sec_time, scl_units, stb_target} = '0;
      {trim_on, trim_int, sec_tr, scl_tr} = '0;
      reset = 1'b1;
      repeat (5) @(negedge core_clk);
      reset = 1'b0;
      pulses = 0;
   endtask

   // n source ticks of 4 cycles; the other oscillator may tick twice as fast meanwhile
   task automatic ticks(input logic use_rc, input int n, input logic noise);
      src_sel = use_rc;
      repeat (n) begin
         for (int k = 0; k < 4; k++) begin
            @(negedge core_clk);
            rc   = use_rc ? (k < 2) : (noise & ~k[0]);
            xtal = use_rc ? (noise & ~k[0]) : (k < 2);
         end
      end
      repeat (3) @(negedge core_clk);
   endtask

   // Hold a clear mask for one cycle
   task automatic clear(input logic [3:0] mask);
      flag_clr = mask;
      @(negedge core_clk);
      flag_clr = 4'h0;
      @(negedge core_clk);
   endtask

   // Counts and verdict, then stop
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      static int exps[3] = '{0, 1, 4};
      int n;
      // Prescaler units and phase on both sources
      foreach (exps[i]) begin
         do_reset();
         unit_exp = exps[i][3:0];
         n = (3 << exps[i]) + 1;
         ticks(i[0], n, 1'b1);
         check(scl_count, n >> exps[i], "unit count");
         check(32'(scl_frac), n & ((1 << exps[i]) - 1), "phase");
      end
      $display("Test prescale done");
      // Absolute and periodic alarms of the scalable counter
      do_reset();
      {scl_en, per_en, scl_units, irq_en} = {1'b1, 1'b1, 32'h0000_0005, 4'h6};
      ticks(1'b0, 4, 1'b1);
      check(flags[1], 1'b0, "alarm early");
      ticks(1'b0, 2, 1'b1);
      check(flags[1], 1'b1, "alarm");
      check(irq, 1'b1, "alarm irq");
      ticks(1'b0, 52, 1'b1);
      check(flags[2], 1'b0, "period early");
      ticks(1'b0, 3, 1'b1);
      check(flags[2], 1'b1, "period");
      check(flags[1], 1'b1, "flag held");
      clear(4'h6);
      check(32'(flags), 32'h0, "cleared");
      check(irq, 1'b0, "irq off");
      ticks(1'b0, 56, 1'b1);
      check(flags[2], 1'b0, "period 2 early");
      ticks(1'b0, 4, 1'b1);
      check(flags[2], 1'b1, "period 2");
      check(flags[1], 1'b0, "no repeat");
      check(scl_count, 32'd121, "crystal only");
      $display("Test alarms done");
      // Alarm to one source cycle inside a unit, and trim every second unit
      do_reset();
      {unit_exp, scl_en, scl_units, scl_frac_t} = {4'h2, 1'b1, 32'h0000_0001, 15'h0002};
      {trim_on, trim_int, scl_tr} = {1'b1, 16'h0001, 8'h03};
      ticks(1'b0, 6, 1'b1);
      check(flags[1], 1'b0, "cycle alarm early");
      ticks(1'b0, 2, 1'b1);
      check(flags[1], 1'b1, "cycle alarm");
      check(scl_count, 32'h0000_0005, "trimmed count");
      check(32'(scl_frac), 32'h0, "trimmed phase");
      $display("Test trim done");
      // Timed pulse and capture in each power mode
      for (int pm = 0; pm < 3; pm++) begin
         do_reset();
         {stb_en, cap_en, wake_en, edge_sel, irq_en} = {3'b111, 2'b01, 4'h8};
         {stb_target, pmode} = {32'h0000_0003, pm[1:0]};
         ticks(1'b0, 2, 1'b1);
         check(pulses, 0, "pulse early");
         check(pulse_oe, 1'b1, "pin driven");
         ticks(1'b0, 4, 1'b1);
         check(pulses, 1, "pulse");
         check(cap_units, 32'h0000_0004, "snapshot units");
         check(32'(cap_frac), 32'h0, "snapshot phase");
         check(flags[3], 1'b1, "capture flag");
         check(irq, 1'b1, "capture irq");
         check(wake_req, pm != 0, "wake");
         // Second pulse at a later target; event line falls this time
         {edge_sel, stb_target} = {2'b10, 32'h0000_0008};
         clear(4'h8);
         ticks(1'b0, 3, 1'b1);
         check(pulses, 2, "second pulse");
         check(cap_units, 32'h0000_0009, "falling snapshot");
         check(flags[3], 1'b1, "falling capture flag");
      end
      $display("Test strobe capture done");
      // Seconds counter, trimmed each second, and its alarm at the end of the first second
      do_reset();
      {sec_en, irq_en} = {1'b1, 4'h1};
      {trim_on, sec_tr} = {1'b1, 8'h04};
      ticks(1'b1, 16383, 1'b1);
      check(scl_count, 32'd16383, "rc count");
      ticks(1'b0, 1, 1'b0);
      check(sec_count, 32'h0, "one tick short");
      check(flags[0], 1'b0, "sec alarm early");
      ticks(1'b0, 1, 1'b0);
      check(sec_count, 32'h5, "one second plus trim");
      check(flags[0], 1'b1, "sec alarm");
      check(irq, 1'b1, "sec irq");
      clear(4'h1);
      check(flags[0], 1'b0, "sec cleared");
      $display("Test seconds done");
      give_verdict();
   end
endmodule // drtc_dual_rtc_tb_top
